// [src/lsa_pkg.sv]
// Behaviour
// - With translation or protection off, bits 28:10 give transfer source physical address.
// - Six-bit mask in bits 5:0; mask bit n governs address bit 10+n.
// - Mask bit clear: that address bit comes from the operand address.
// - Mask bit set: that address bit comes from the stored address field.
// - Protection enable bit decides whether translation-based checks apply to local memory; the code applies them only when the translation enable is also set.
package lsa_pkg;
  localparam logic [3:0] LSA_OFF_SRC = 4'h0;
  localparam logic [3:0] LSA_OFF_CTRL = 4'h4;
  localparam int LSA_ADDR_LSB = 10;
  localparam int LSA_ADDR_MSB = 28;
  localparam int LSA_MASK_MSB = 5;
  localparam int LSA_CTRL_AT_BIT = 0;
  localparam int LSA_CTRL_RP_BIT = 8;
  localparam logic [1:0] LSA_CTRL_RESET = 2'h0;
  localparam logic [18:0] LSA_ADDR_RESET = 19'h00000;
  localparam logic [5:0] LSA_MASK_RESET = 6'h00;
  localparam int LSA_WAIT_CYCLES = 1;
endpackage

// [src/lsa_page0_src.sv]
`timescale 1ns/1ps
module lsa_page0_src
  import lsa_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [ADDR_W-1:0] i_operand_addr,
  output logic [ADDR_W-1:0] o_src_phys_addr,
  output logic o_src_override_active,
  output logic o_protection_checks
);
  // The merge slices below assume a 32-bit physical address, so refuse any other width.
  if (ADDR_W != 32) begin : g_bad_width
    $error("lsa_page0_src supports only a 32-bit address");
  end

  logic [18:0] addr_field_q;
  logic [5:0] mask_q;
  logic at_en_q;
  logic rp_en_q;
  logic ack_q;
  logic [31:0] src_word;
  logic [31:0] ctrl_word;

  // Register word with reserved bits forced to zero.
  function automatic logic [31:0] lsa_pack(input logic [18:0] a, input logic [5:0] m);
    lsa_pack = {3'h0, a, 4'h0, m};
  endfunction

  assign src_word = lsa_pack(addr_field_q, mask_q);
  assign ctrl_word = {23'h000000, rp_en_q, 7'h00, at_en_q};

  // One wait cycle per access; ack drops waitrequest for exactly one edge.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;

  // Address field and mask: byte-lane writes, reserved bits dropped.
  // Software must treat both as undefined after reset; a known value keeps the merge clean.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      addr_field_q <= LSA_ADDR_RESET;
      mask_q <= LSA_MASK_RESET;
    end else if (i_ce && i_avs_write && ack_q && i_avs_address == LSA_OFF_SRC) begin
      if (i_avs_byteenable[0]) begin
        mask_q <= i_avs_writedata[LSA_MASK_MSB:0];
      end
      if (i_avs_byteenable[1]) begin
        addr_field_q[5:0] <= i_avs_writedata[15:10];
      end
      if (i_avs_byteenable[2]) begin
        addr_field_q[13:6] <= i_avs_writedata[23:16];
      end
      if (i_avs_byteenable[3]) begin
        addr_field_q[18:14] <= i_avs_writedata[LSA_ADDR_MSB:24];
      end
    end
  end

  // Translation and protection enables mirrored from the system control registers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      {rp_en_q, at_en_q} <= LSA_CTRL_RESET;
    end else if (i_ce && i_avs_write && ack_q && i_avs_address == LSA_OFF_CTRL) begin
      if (i_avs_byteenable[0]) begin
        at_en_q <= i_avs_writedata[LSA_CTRL_AT_BIT];
      end
      if (i_avs_byteenable[1]) begin
        rp_en_q <= i_avs_writedata[LSA_CTRL_RP_BIT];
      end
    end
  end

  // Read data registered; unmapped offsets read zero.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_ce && i_avs_read && !ack_q) begin
      case (i_avs_address)
        LSA_OFF_SRC: o_avs_readdata <= src_word;
        LSA_OFF_CTRL: o_avs_readdata <= ctrl_word;
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  assign o_protection_checks = at_en_q && rp_en_q;
  assign o_src_override_active = !o_protection_checks;

  // Per-bit merge of bits 15:10; upper bits from the field when the register applies.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_src_phys_addr <= 32'h00000000;
    end else if (i_ce) begin
      o_src_phys_addr <= i_operand_addr;
      if (o_src_override_active) begin
        for (int n = 0; n <= LSA_MASK_MSB; n++) begin
          o_src_phys_addr[LSA_ADDR_LSB+n] <= mask_q[n] ? addr_field_q[n]
                                                       : i_operand_addr[LSA_ADDR_LSB+n];
        end
        o_src_phys_addr[LSA_ADDR_MSB:16] <= addr_field_q[18:6];
        o_src_phys_addr[31:29] <= 3'h0;
      end
    end
  end

  property p_merge_bit;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !o_protection_checks && mask_q[0] && $stable(mask_q) && $stable(addr_field_q))
        |=> o_src_phys_addr[10] == $past(addr_field_q[0]);
  endproperty
  a_merge_bit: assert property (p_merge_bit) else $error("masked bit not from field");

  property p_operand_bit;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !o_protection_checks && !mask_q[5])
        |=> o_src_phys_addr[15] == $past(i_operand_addr[15]);
  endproperty
  a_operand_bit: assert property (p_operand_bit) else $error("clear bit not from operand");

  property p_upper_field;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !o_protection_checks)
        |=> o_src_phys_addr[28:16] == $past(addr_field_q[18:6]);
  endproperty
  a_upper_field: assert property (p_upper_field) else $error("upper field not used");

  property p_translated;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && o_protection_checks) |=> o_src_phys_addr == $past(i_operand_addr);
  endproperty
  a_translated: assert property (p_translated) else $error("override while protected");

  property p_reserved;
    @(posedge i_clk) disable iff (i_reset)
      (i_avs_read && !o_avs_waitrequest && i_avs_address == LSA_OFF_SRC)
        |-> o_avs_readdata[31:29] == 3'h0 && o_avs_readdata[9:6] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_mask_write;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_avs_write && !o_avs_waitrequest && i_avs_address == LSA_OFF_SRC
       && i_avs_byteenable[0]) |=> mask_q == $past(i_avs_writedata[5:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  // A bus access opens with waitrequest high while the slave is not yet ready.
  sequence s_req_start;
    i_ce && (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence

  // The access ends when waitrequest is seen low.
  sequence s_req_done;
    !o_avs_waitrequest;
  endsequence

  // Every access is answered after exactly one wait cycle.
  property p_one_wait;
    @(posedge i_clk) disable iff (i_reset)
      s_req_start |=> s_req_done;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("access not answered in one cycle");

  // No pending acknowledge survives an idle cycle.
  property p_idle_ack;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !i_avs_read && !i_avs_write) |=> !ack_q;
  endproperty
  a_idle_ack: assert property (p_idle_ack) else $error("acknowledge without request");

  // A completed read of the source register returns both stored fields.
  property p_read_src;
    @(posedge i_clk) disable iff (i_reset)
      (i_avs_read && !o_avs_waitrequest && i_avs_address == LSA_OFF_SRC)
        |-> o_avs_readdata[28:10] == addr_field_q && o_avs_readdata[5:0] == mask_q;
  endproperty
  a_read_src: assert property (p_read_src) else $error("source read mismatch");

  // A completed read of the control word returns both enables in place.
  property p_read_ctrl;
    @(posedge i_clk) disable iff (i_reset)
      (i_avs_read && !o_avs_waitrequest && i_avs_address == LSA_OFF_CTRL)
        |-> o_avs_readdata == {23'h000000, rp_en_q, 7'h00, at_en_q};
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read mismatch");

  // Unmapped offsets always read back as zero.
  property p_read_unmapped;
    @(posedge i_clk) disable iff (i_reset)
      (i_avs_read && !o_avs_waitrequest && i_avs_address != LSA_OFF_SRC
       && i_avs_address != LSA_OFF_CTRL) |-> o_avs_readdata == 32'h00000000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read nonzero");

  // Writes to unmapped offsets leave every stored bit alone.
  property p_unmapped_write;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_avs_write && !o_avs_waitrequest && i_avs_address != LSA_OFF_SRC
       && i_avs_address != LSA_OFF_CTRL)
        |=> $stable(mask_q) && $stable(addr_field_q) && $stable({rp_en_q, at_en_q});
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  // A full-word write loads the whole address field from bits 28:10.
  property p_field_write;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_avs_write && !o_avs_waitrequest && i_avs_address == LSA_OFF_SRC
       && i_avs_byteenable == 4'hF) |=> addr_field_q == $past(i_avs_writedata[28:10]);
  endproperty
  a_field_write: assert property (p_field_write) else $error("field not written");

  // A control write with both low lanes loads both enables.
  property p_ctrl_write;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_avs_write && !o_avs_waitrequest && i_avs_address == LSA_OFF_CTRL
       && i_avs_byteenable[1:0] == 2'h3)
        |=> {rp_en_q, at_en_q} == {$past(i_avs_writedata[8]), $past(i_avs_writedata[0])};
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enables not written");

  // The six merge bits follow the mask bit by bit while the register applies.
  property p_merge_all;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !o_protection_checks)
        |=> o_src_phys_addr[15:10] == (($past(mask_q) & $past(addr_field_q[5:0]))
                                       | (~$past(mask_q) & $past(i_operand_addr[15:10])));
  endproperty
  a_merge_all: assert property (p_merge_all) else $error("merge bits wrong");

  // The low ten bits always come from the operand address.
  property p_low_bits;
    @(posedge i_clk) disable iff (i_reset)
      i_ce |=> o_src_phys_addr[9:0] == $past(i_operand_addr[9:0]);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low bits not from operand");

  // The top three bits are zero while the register supplies the address.
  property p_top_zero;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !o_protection_checks) |=> o_src_phys_addr[31:29] == 3'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("top bits nonzero");

  // Override is active exactly when translation or protection is off.
  property p_override_level;
    @(posedge i_clk) disable iff (i_reset)
      o_src_override_active == (!at_en_q || !rp_en_q);
  endproperty
  a_override_level: assert property (p_override_level) else $error("override level wrong");

  // A low clock enable freezes all state.
  property p_freeze;
    @(posedge i_clk) disable iff (i_reset)
      !i_ce |=> $stable(o_src_phys_addr) && $stable(mask_q) && $stable(addr_field_q)
                && $stable(ack_q) && $stable(o_avs_readdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  // Reset clears the address and read-data outputs and turns the protection checks off.
  property p_reset_out;
    @(posedge i_clk)
      i_reset |=> o_src_phys_addr == 32'h00000000 && o_avs_readdata == 32'h00000000
                  && !o_protection_checks;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset values wrong");
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import lsa_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] op = 32'h0;
  logic [31:0] rdata, pa;
  logic wait_q, ovr, chk;
  logic ce = 1'b1;
  logic [5:0] pats [7] = '{6'h3F, 6'h3E, 6'h3C, 6'h38, 6'h30, 6'h20, 6'h00};
  logic [31:0] ctrls [4] = '{32'h0, 32'h1, 32'h100, 32'h101};
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  // Free-running clock, 8 ns period.
  always #4 i_clk = ~i_clk;
  lsa_page0_src u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_q), .i_operand_addr(op),
    .o_src_phys_addr(pa), .o_src_override_active(ovr), .o_protection_checks(chk));
  // Compares one value and reports a mismatch.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge i_clk);
    while (wait_q !== 1'b0) begin
      @(posedge i_clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask
  // Walks every legal granularity mask with override active.
  task automatic masks();
    logic [18:0] f;
    logic [31:0] q;
    f = 19'h5A5A5;
    op <= 32'hA5A5A5A5;
    bus(1'b1, LSA_OFF_CTRL, 32'h0, q);
    foreach (pats[i]) begin
      bus(1'b1, LSA_OFF_SRC, {3'b111, f, 4'hF, pats[i]}, q);
      bus(1'b0, LSA_OFF_SRC, 32'h0, q);
      chk32(q, {3'b000, f, 4'h0, pats[i]});
      repeat (2) @(posedge i_clk);
      chk32(pa, {3'b000, f[18:6], (pats[i] & f[5:0]) | (~pats[i] & op[15:10]), op[9:0]});
      f = f + 19'h0B1C3;
    end
  endtask
  // Tries each pair of enables and checks which address reaches the output.
  task automatic ctrl();
    logic [31:0] q;
    logic ov;
    bus(1'b1, LSA_OFF_SRC, {3'b000, 19'h7FFFF, 4'h0, 6'h3F}, q);
    foreach (ctrls[i]) begin
      bus(1'b1, LSA_OFF_CTRL, ctrls[i], q);
      bus(1'b0, LSA_OFF_CTRL, 32'h0, q);
      chk32(q, ctrls[i]);
      op <= 32'h86421357 + i;
      repeat (2) @(posedge i_clk);
      ov = !(ctrls[i][0] && ctrls[i][8]);
      chk32({30'h0, chk, ovr}, {30'h0, !ov, ov});
      chk32(pa, ov ? {3'b000, 19'h7FFFF, op[9:0]} : op);
    end
  endtask
  // Unmapped offsets read zero and leave the source register alone.
  task automatic unmapped();
    logic [31:0] q;
    bus(1'b1, 4'h8, 32'hFFFFFFFF, q);
    bus(1'b0, 4'h8, 32'h0, q);
    chk32(q, 32'h0);
    bus(1'b0, LSA_OFF_SRC, 32'h0, q);
    chk32(q, {3'b000, 19'h7FFFF, 4'h0, 6'h3F});
  endtask
  // Clock enable low must freeze the merged address while the operand moves.
  task automatic freeze();
    logic [31:0] p0;
    p0 = pa;
    ce <= 1'b0;
    op <= ~op;
    repeat (3) @(posedge i_clk);
    chk32(pa, p0);
    ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk32(pa[9:0], {22'h0, op[9:0]});
  endtask
  // A reset in mid-run clears both enables, so the override comes back.
  task automatic rst_mid();
    logic [31:0] q;
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chk32({30'h0, chk, ovr}, 32'h1);
    bus(1'b0, LSA_OFF_CTRL, 32'h0, q);
    chk32(q, 32'h0);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chk32({31'h0, ovr}, 32'h1);
    masks();
    ctrl();
    unmapped();
    freeze();
    rst_mid();
    close_out();
  end
endmodule
